// *** aoncc_pkg.sv ***
/*
  Package for the always-on memory command control block: register offsets,
  field positions, reset values and sizes.
  Assumes a classic Wishbone slave with 8-bit byte-wide registers on word addresses.
*/
package aoncc_pkg;
  localparam int        AONCC_DW          = 8;
  localparam int        AONCC_AW          = 8;
  localparam int        AONCC_MEM_DEPTH   = 256;
  localparam int        AONCC_CFG_WORDS   = 16;
  // Printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTRL         = 8'h02;
  localparam logic [7:0] IDX_RDAT         = 8'h03;
  localparam logic [7:0] IDX_ADDR         = 8'h04;
  localparam logic [7:0] IDX_CFG0         = 8'h06;
  localparam logic [7:0] IDX_CFG1         = 8'h0a;
  localparam logic [7:0] IDX_SLEEP        = 8'h10;
  localparam logic [7:0] IDX_USER_BASE    = 8'h20;
  localparam int        BIT_RESTORE       = 0;
  localparam int        BIT_SAVE          = 1;
  localparam int        BIT_UPLOAD        = 2;
  localparam int        BIT_DREAD         = 3;
  localparam int        BIT_DENAB         = 7;
  localparam logic [7:0] CTRL_WRITE_MASK  = 8'h8f;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [7:0] AON_CFG_BASE     = 8'hf0;
  localparam int        SLP_BIT_ENTER     = 0;
  localparam int        SLP_BIT_WAKE      = 1;
  localparam int        SLP_BIT_BUSY      = 7;
  typedef enum logic [1:0] {
    AONCC_IDLE = 2'b00,
    AONCC_COPY = 2'b01,
    AONCC_UPL  = 2'b11,
    AONCC_DONE = 2'b10
  } aoncc_state_t;
endpackage

// *** aoncc_mem.sv ***
/*
  Always-on memory array: one write port, one read port with registered data.
  Assumes a single clock; contents are not reset, as in a retention store.
*/
module aoncc_mem
  import aoncc_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Write port
  input  wire logic                we,
  input  wire logic [AONCC_AW-1:0] waddr,
  input  wire logic [AONCC_DW-1:0] wdata,
  // Read port
  input  wire logic [AONCC_AW-1:0] raddr,
  output      logic [AONCC_DW-1:0] rdata
);
  logic [AONCC_DW-1:0] mem [AONCC_MEM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** aoncc_top.sv ***
/*
  Always-on memory command control register bank with Wishbone slave.
  Assumes a classic Wishbone master holding requests until ack.
*/
// Our own choice: the Wishbone interface to the registers.
// Function
// - An 8-bit read-write command register exists and resets to all zeros.
// - Writing command bit 0, 1 or 3 starts its activity and the device clears it when done.
// - Bit 0 restores user configuration from always-on memory, then clears itself.
// - Bit 1 saves user configuration to always-on memory, uploads config, then clears.
// - Bit 2 copies both low-power config registers into always-on config and stays set.
// - Bit 3 with access enabled reads the addressed location into the result register.
// - A direct read happens only while enable bit 7 is one.
// - Automatic sleep save and wake restore run only while the enable bit is zero.
// - An 8-bit read-write address register selects the direct-read location.
// - An 8-bit register returns the byte of the latest direct read.
module aoncc_top
  import aoncc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  // Always-on configuration seen by the power controller
  output      logic [7:0]  aon_cfg_first,
  output      logic [7:0]  aon_cfg_second
);
  logic [7:0]      ctrl_reg;
  logic [7:0]      addr_reg;
  logic [7:0]      rdat_reg;
  logic [7:0]      cfg0_reg;
  logic [7:0]      cfg1_reg;
  logic [7:0]      user_reg [AONCC_CFG_WORDS];
  logic            sleep_enter_reg;
  logic            wake_reg;
  logic            auto_restore_reg;
  logic [3:0]      cnt_reg;
  logic            rd_pend_reg;
  aoncc_state_t    state_reg;
  logic            req;
  logic            wr_lane;
  logic [7:0]      idx;
  logic [7:0]      wbyte;
  logic            mem_we;
  logic [7:0]      mem_waddr;
  logic [7:0]      mem_wdata;
  logic [7:0]      mem_raddr;
  logic [7:0]      mem_rdata;
  logic            saving_reg;

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx     = wb_adr_i[9:2];
  // Writes commit at the edge where the master samples ack, not at the take edge
  assign wr_lane = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  // One wait state: ack follows the request by one cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      if (idx == IDX_CTRL)
        wb_dat_o[7:0] <= ctrl_reg;
      else if (idx == IDX_RDAT)
        wb_dat_o[7:0] <= rdat_reg;
      else if (idx == IDX_ADDR)
        wb_dat_o[7:0] <= addr_reg;
      else if (idx == IDX_CFG0)
        wb_dat_o[7:0] <= cfg0_reg;
      else if (idx == IDX_CFG1)
        wb_dat_o[7:0] <= cfg1_reg;
      else if (idx == IDX_SLEEP)
        wb_dat_o[7:0] <= {state_reg != AONCC_IDLE, 7'h00};
      else if (idx[7:4] == IDX_USER_BASE[7:4])
        wb_dat_o[7:0] <= user_reg[idx[3:0]];
    end
  end

  // Command register; self-clearing bits clear when their activity ends
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_reg <= CTRL_RESET;
    else
    begin
      if (wr_lane && idx == IDX_CTRL)
        ctrl_reg <= wbyte & CTRL_WRITE_MASK;
      else
      begin
        if (state_reg == AONCC_DONE && !auto_restore_reg)
        begin
          ctrl_reg[BIT_RESTORE] <= 1'b0;
          ctrl_reg[BIT_SAVE]    <= 1'b0;
        end
        if (rd_pend_reg || (ctrl_reg[BIT_DREAD] && !ctrl_reg[BIT_DENAB]))
          ctrl_reg[BIT_DREAD] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_reg <= CFG_RESET;
      cfg0_reg <= CFG_RESET;
      cfg1_reg <= CFG_RESET;
      sleep_enter_reg <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      if (wr_lane && idx == IDX_ADDR)
        addr_reg <= wbyte;
      if (wr_lane && idx == IDX_CFG0)
        cfg0_reg <= wbyte;
      if (wr_lane && idx == IDX_CFG1)
        cfg1_reg <= wbyte;
      sleep_enter_reg <= wr_lane && idx == IDX_SLEEP && wbyte[SLP_BIT_ENTER];
      wake_reg <= wr_lane && idx == IDX_SLEEP && wbyte[SLP_BIT_WAKE];
    end
  end

  // Upload of low-power configuration; level-held while bit 2 stays set
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aon_cfg_first  <= CFG_RESET;
      aon_cfg_second <= CFG_RESET;
    end
    else if (ctrl_reg[BIT_UPLOAD] || state_reg == AONCC_UPL)
    begin
      aon_cfg_first  <= cfg0_reg;
      aon_cfg_second <= cfg1_reg;
    end
  end

  // Sequencer for save and restore, manual or automatic
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= AONCC_IDLE;
      cnt_reg <= 4'h0;
      saving_reg <= 1'b0;
      auto_restore_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        AONCC_IDLE:
        begin
          cnt_reg <= 4'h0;
          auto_restore_reg <= 1'b0;
          if (ctrl_reg[BIT_SAVE] || (sleep_enter_reg && !ctrl_reg[BIT_DENAB]))
          begin
            saving_reg <= 1'b1;
            state_reg <= AONCC_COPY;
          end
          else if (ctrl_reg[BIT_RESTORE] || (wake_reg && !ctrl_reg[BIT_DENAB]))
          begin
            saving_reg <= 1'b0;
            auto_restore_reg <= !ctrl_reg[BIT_RESTORE];
            state_reg <= AONCC_COPY;
          end
        end
        AONCC_COPY:
        begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'hf)
            state_reg <= saving_reg ? AONCC_UPL : AONCC_DONE;
        end
        AONCC_UPL:
          state_reg <= AONCC_DONE;
        AONCC_DONE:
          state_reg <= AONCC_IDLE;
      endcase
    end
  end

  // Restore lands one cycle late because memory data is registered
  logic            rst_wr_reg;
  logic [3:0]      rst_idx_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_wr_reg <= 1'b0;
      rst_idx_reg <= 4'h0;
    end
    else
    begin
      rst_wr_reg <= state_reg == AONCC_COPY && !saving_reg;
      rst_idx_reg <= cnt_reg;
    end
  end

  generate
    for (genvar i = 0; i < AONCC_CFG_WORDS; i++)
    begin : g_user
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          user_reg[i] <= CFG_RESET;
        else if (wr_lane && idx == IDX_USER_BASE + 8'(i))
          user_reg[i] <= wbyte;
        else if (rst_wr_reg && rst_idx_reg == 4'(i))
          user_reg[i] <= mem_rdata;
      end
    end
  endgenerate

  // Direct read: launch only when enabled, result lands two cycles later
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_pend_reg <= 1'b0;
      rdat_reg <= CFG_RESET;
    end
    else
    begin
      rd_pend_reg <= ctrl_reg[BIT_DREAD] && ctrl_reg[BIT_DENAB] && !rd_pend_reg
                     && state_reg == AONCC_IDLE;
      if (rd_pend_reg)
        rdat_reg <= mem_rdata;
    end
  end

  assign mem_we    = state_reg == AONCC_COPY && saving_reg;
  assign mem_waddr = {4'h0, cnt_reg};
  assign mem_wdata = user_reg[cnt_reg];
  assign mem_raddr = state_reg == AONCC_COPY ? {4'h0, cnt_reg} : addr_reg;

  aoncc_mem u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  a_reset_ctrl_zero: assert property (@(posedge clk) $rose(rst_b) |-> ctrl_reg == 8'h00)
    else $error("ctrl not zero after reset");
  a_read_needs_enable: assert property (@(posedge clk) disable iff (!rst_b)
    rd_pend_reg |-> $past(ctrl_reg[BIT_DENAB]))
    else $error("direct read without enable");
  a_rdat_holds: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(rd_pend_reg) |-> $stable(rdat_reg))
    else $error("result changed without read");
  a_read_loads: assert property (@(posedge clk) disable iff (!rst_b)
    rd_pend_reg |=> rdat_reg == $past(mem_rdata))
    else $error("result not loaded");
  a_upload_copies: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_reg[BIT_UPLOAD] |=> aon_cfg_first == $past(cfg0_reg))
    else $error("upload did not copy");
  a_upload_sticks: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_reg[BIT_UPLOAD] && !(wr_lane && idx == IDX_CTRL) |=> ctrl_reg[BIT_UPLOAD])
    else $error("upload bit cleared itself");
  a_save_clears: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == AONCC_IDLE && ctrl_reg[BIT_SAVE] && !sleep_enter_reg
    |-> ##[1:20] !ctrl_reg[BIT_SAVE])
    else $error("save not cleared");
  a_restore_clears: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == AONCC_IDLE && ctrl_reg[BIT_RESTORE] |-> ##[1:40] !ctrl_reg[BIT_RESTORE])
    else $error("restore not cleared");
  a_auto_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == AONCC_IDLE && ctrl_reg[7] && !ctrl_reg[1] && !ctrl_reg[0]
    |=> state_reg == AONCC_IDLE)
    else $error("auto save ran while enabled");
  c_save: cover property (@(posedge clk) state_reg == AONCC_UPL);
  c_dread: cover property (@(posedge clk) rd_pend_reg);
  c_restore: cover property (@(posedge clk) rst_wr_reg);
endmodule

// *** aoncc_test.sv ***
/*
  Self-checking bench for the always-on memory command control block.
  Assumes aoncc_top with a classic Wishbone slave that answers one cycle after taking a request.
*/
module aoncc_test
  import aoncc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_b;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  aon_cfg_first;
  logic [7:0]  aon_cfg_second;
  int          fails;
  int          comparisons;

  aoncc_top dut_u (
    .clk            (clk),
    .rst_b          (rst_b),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .aon_cfg_first  (aon_cfg_first),
    .aon_cfg_second (aon_cfg_second)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic complete_run;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stays put until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                         output logic [7:0] q);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    if (n >= 20)
      check(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb_xfer(1'b0, idx, 8'h00, q);
    check(q, exp);
  endtask

  // Bounded poll: commands take tens of cycles, so a long wait is a hang
  task automatic poll(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] q;
    int         n;
    n = 0;
    do
    begin
      wb_xfer(1'b0, idx, 8'h00, q);
      n++;
    end
    while ((q & mask) !== exp && n < 60);
    check(q & mask, exp);
  endtask

  function automatic logic [7:0] pat(input int i);
    return {i[3:0], ~i[3:0]};
  endfunction

  initial
  begin
    fails = 0;
    comparisons = 0;
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(IDX_CTRL, 8'h00);
    rd(IDX_RDAT, 8'h00);
    rd(8'h05, 8'h00);
    wr(IDX_ADDR, 8'ha5);
    rd(IDX_ADDR, 8'ha5);
    for (int i = 0; i < AONCC_CFG_WORDS; i++)
      wr(IDX_USER_BASE + 8'(i), pat(i));
    wr(IDX_CFG0, 8'h3c);
    wr(IDX_CFG1, 8'h5a);
    // Reserved bits 6:4 are always written as zero
    wr(IDX_CTRL, 8'h02);
    poll(IDX_CTRL, 8'hff, 8'h00);
    check(aon_cfg_first, 8'h3c);
    check(aon_cfg_second, 8'h5a);
    for (int i = 0; i < AONCC_CFG_WORDS; i++)
      wr(IDX_USER_BASE + 8'(i), 8'h00);
    wr(IDX_CTRL, 8'h01);
    poll(IDX_CTRL, 8'hff, 8'h00);
    for (int i = 0; i < AONCC_CFG_WORDS; i++)
      rd(IDX_USER_BASE + 8'(i), pat(i));
    wr(IDX_ADDR, 8'h05);
    wr(IDX_CTRL, 8'h88);
    poll(IDX_CTRL, 8'hff, 8'h80);
    rd(IDX_RDAT, pat(5));
    wr(IDX_ADDR, 8'h06);
    wr(IDX_CTRL, 8'h08);
    poll(IDX_CTRL, 8'hff, 8'h00);
    rd(IDX_RDAT, pat(5));
    wr(IDX_CFG0, 8'h11);
    wr(IDX_CFG1, 8'h22);
    wr(IDX_CTRL, 8'h04);
    rd(IDX_CTRL, 8'h04);
    check(aon_cfg_first, 8'h11);
    check(aon_cfg_second, 8'h22);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_CTRL, 8'h00);
    // Sleep save with direct access still enabled must leave memory alone
    wr(IDX_CTRL, 8'h80);
    wr(IDX_USER_BASE, 8'h77);
    wr(IDX_SLEEP, 8'h01);
    poll(IDX_SLEEP, 8'h80, 8'h00);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h01);
    poll(IDX_CTRL, 8'hff, 8'h00);
    rd(IDX_USER_BASE, pat(0));
    wr(IDX_USER_BASE, 8'h77);
    wr(IDX_SLEEP, 8'h01);
    poll(IDX_SLEEP, 8'h80, 8'h00);
    wr(IDX_USER_BASE, 8'h00);
    wr(IDX_SLEEP, 8'h02);
    poll(IDX_SLEEP, 8'h80, 8'h00);
    rd(IDX_USER_BASE, 8'h77);
    complete_run;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run;
  end
endmodule
